// file: core/trace_buffer_consts.svh
// Offsets, field positions, reset values and counts of the trace buffer.
// Assumes an 8-bit register address and 16-bit register data.
`ifndef TRACE_BUFFER_CONSTS_SVH
`define TRACE_BUFFER_CONSTS_SVH

// Register offsets.
`define FIRST_DEBUG_CONTROL_OFS    8'h00
`define TRACE_CONTROL_REGISTER_OFS 8'h01
`define DEBUG_STATUS_REGISTER_OFS  8'h02
`define TRACE_LINE_COUNT_OFS       8'h03
`define TRACE_WINDOW_HIGH_OFS      8'h04
`define TRACE_WINDOW_LOW_OFS       8'h05

// Field positions.
`define SESSION_ENABLE_BIT 7
`define BREAKPOINT_EN_BIT  0
`define TRACE_SOURCE_BIT   0
`define ALIGN_LSB          1
`define BUFFER_FULL_BIT    7

// Reset values and fixed figures.
`define CTRL_RESET       8'h00
`define COUNT_RESET      7'h00
`define INVALID_WORD     16'h0000
`define MID_TRACE_LINES  6'h20
`define COUNT_FULL_STEP  8'h02
`define COUNT_HALF_STEP  8'h01

`endif

// file: core/trace_buffer_pkg.sv
// Types shared by the trace buffer and whoever drives it.
// Assumes the constants header sits in the same include path.
`default_nettype none
package trace_buffer_pkg;
	// Trigger alignment codes; the unused code behaves as end alignment.
	typedef enum logic [1:0] {
		ALIGN_END   = 2'b00,
		ALIGN_MID   = 2'b01,
		ALIGN_BEGIN = 2'b10,
		ALIGN_RSVD  = 2'b11
	} align_t;

	// Session states; idle is the disarmed state zero.
	typedef enum logic [1:0] {
		SES_IDLE  = 2'b00,
		SES_ARMED = 2'b01,
		SES_RUN   = 2'b10,
		SES_POST  = 2'b11
	} session_t;

	// One register access from software.
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	// One store offered by the processor trace source.
	typedef struct packed {
		logic        valid;
		logic        half;
		logic [63:0] data;
	} trace_in_t;
endpackage : trace_buffer_pkg
`default_nettype wire

// file: core/debug_trace_buffer_counter.sv
// Trace store of the debug unit: circular line RAM, line counter, full
// flag, session control at the final sequencer state and read window.
// Assumes all inputs come from logic on ref_clk; rst is power-on only.
//
// Summary of operation
// - Seven-bit read-only counter tells how many trace half-lines are held.
// - Counter wrap sets the full flag; end and mid alignment keep counting.
// - Writing one to the session enable bit clears the counter.
// - Of the two resets only power-on reset clears the counter; system reset leaves it.
// - Counter bit zero counts a 32-bit half line; two means one line.
// - Full with zero count means 64 lines; begin alignment then disarms.
// - Full with nonzero count means 64 lines, oldest overwritten.
// - Entering final state may trigger the trace buffer per alignment.
// - Trace source cleared disables the buffer; final gives only breakpoint.
// - Disabled trace or finished session clears enable and returns to idle.
// - With tracing, breakpoint is raised when the session finishes.
// - Neither tracing nor breakpoints: final state returns to idle disarmed.
// - Trace store is 64 lines of 64 bits, written circularly.
// - After a whole line is read the read pointer moves to the next line.
// - Every store into the RAM increments the counter.
// - No tracing while background debug mode is active.
// - Window reads while armed give invalid data and keep the pointer.
// - Mid alignment stores 32 more lines after trigger, then disarms.
// - Begin alignment stores only after final, then 64 lines, then disarms.
// - End and mid tracing start once enabled and the first state is entered.
//
// Strobed register access and the register offsets are this design's own decisions.
`include "trace_buffer_consts.svh"
`default_nettype none
module debug_trace_buffer_counter (
	input  wire logic                        ref_clk,
	input  wire logic                        rst,
	input  wire logic                        sys_reset,
	input  wire trace_buffer_pkg::reg_req_t  req,
	output var  logic [15:0]                 rdata,
	input  wire trace_buffer_pkg::trace_in_t trace_in,
	input  wire logic                        enter_first_state,
	input  wire logic                        enter_final_state,
	input  wire logic                        background_debug_mode,
	output var  logic                        trigger_out,
	output var  logic                        breakpoint_req,
	output var  trace_buffer_pkg::session_t  session
);
	import trace_buffer_pkg::*;

	// Storage and state.
	logic [31:0] mem_hi [64];
	logic [31:0] mem_lo [64];
	logic [6:0]  line_count_reg;
	logic [6:0]  line_count_next;
	logic        buffer_full_flag_reg;
	logic        buffer_full_flag_next;
	logic [7:0]  first_debug_control_reg;
	logic [7:0]  trace_control_register_reg;
	session_t    session_reg;
	session_t    session_next;
	logic [5:0]  wptr_reg;
	logic [5:0]  rptr_reg;
	logic [5:0]  rptr_next;
	logic [1:0]  word_idx_reg;
	logic [5:0]  mid_left_reg;
	logic [15:0] rdata_reg;
	logic        trigger_reg;
	logic        breakpoint_reg;

	// Register decode.
	wire logic wr_ctrl1  = req.wr && req.addr == `FIRST_DEBUG_CONTROL_OFS;
	wire logic wr_tcr    = req.wr && req.addr == `TRACE_CONTROL_REGISTER_OFS;
	wire logic arm_write = wr_ctrl1 && req.wdata[`SESSION_ENABLE_BIT];
	wire logic disarm_wr = wr_ctrl1 && !req.wdata[`SESSION_ENABLE_BIT];
	wire logic win_rd    = req.rd && (req.addr == `TRACE_WINDOW_HIGH_OFS
		|| req.addr == `TRACE_WINDOW_LOW_OFS);
	wire logic armed     = session_reg != SES_IDLE;
	wire logic bkpt_en   = first_debug_control_reg[`BREAKPOINT_EN_BIT];
	wire logic trace_src = trace_control_register_reg[`TRACE_SOURCE_BIT];
	wire align_t align   = align_t'(trace_control_register_reg[2:1]);
	wire logic is_begin  = align == ALIGN_BEGIN;
	wire logic is_mid    = align == ALIGN_MID;

	// Storing is allowed only in a live phase and never under debug mode.
	wire logic phase_store = (session_reg == SES_RUN && !is_begin)
		|| session_reg == SES_POST;
	wire logic store = trace_in.valid && phase_store && trace_src
		&& !background_debug_mode;
	// A half store adds one, a full line adds two to the counter.
	wire logic [7:0] step = trace_in.half ? `COUNT_HALF_STEP
		: `COUNT_FULL_STEP;
	wire logic [7:0] count_sum = {1'b0, line_count_reg} + step;
	wire logic wrap = store && count_sum[7];
	// A line is complete on a full store or on the second half.
	wire logic line_done = store
		&& (!trace_in.half || line_count_reg[0]);
	wire logic final_hit = enter_final_state
		&& (session_reg == SES_ARMED || session_reg == SES_RUN);
	wire logic begin_done = session_reg == SES_POST && is_begin
		&& wrap;
	wire logic mid_done = session_reg == SES_POST && is_mid
		&& line_done && mid_left_reg == 6'h01;
	wire logic end_done = final_hit && trace_src && !is_begin
		&& !is_mid;
	wire logic finish = begin_done || mid_done || end_done
		|| (final_hit && !trace_src);
	wire logic [5:0] wptr_inc = wptr_reg + 6'h01;

	// Session sequence; software may disarm at any time.
	always_comb begin
		session_next = session_reg;
		unique case (session_reg)
			SES_IDLE: begin
				if (arm_write)
					session_next = SES_ARMED;
			end
			SES_ARMED: begin
				if (enter_first_state)
					session_next = SES_RUN;
			end
			SES_RUN: begin
				if (final_hit && trace_src && (is_begin || is_mid))
					session_next = SES_POST;
			end
			SES_POST: begin
				session_next = SES_POST;
			end
		endcase
		if (final_hit && session_reg == SES_ARMED && trace_src
			&& (is_begin || is_mid))
			session_next = SES_POST;
		if (finish || disarm_wr)
			session_next = SES_IDLE;
		if (sys_reset)
			session_next = SES_IDLE;
	end

	// Counter and full flag; of the two resets only the power-on reset touches them.
	always_comb begin
		line_count_next = line_count_reg;
		buffer_full_flag_next = buffer_full_flag_reg;
		if (store)
			line_count_next = count_sum[6:0];
		if (wrap)
			buffer_full_flag_next = 1'b1;
		if (arm_write) begin
			line_count_next = `COUNT_RESET;
			buffer_full_flag_next = 1'b0;
		end
	end

	// When a session ends the reader starts at wptr_reg if the buffer has wrapped, else at line zero.
	always_comb begin
		rptr_next = rptr_reg;
		if (session_reg != SES_IDLE && session_next == SES_IDLE)
			rptr_next = (buffer_full_flag_next || wrap) ? wptr_reg : 6'h00;
		else if (win_rd && !armed && word_idx_reg == 2'h3)
			rptr_next = rptr_reg + 6'h01;
	end

	// Window words go high half of line first, then low half.
	wire logic [63:0] rd_line = {mem_hi[rptr_reg], mem_lo[rptr_reg]};
	logic [15:0] win_word;
	always_comb begin
		unique case (word_idx_reg)
			2'h0: win_word = rd_line[63:48];
			2'h1: win_word = rd_line[47:32];
			2'h2: win_word = rd_line[31:16];
			2'h3: win_word = rd_line[15:0];
		endcase
	end

	// Read mux; unmapped offsets read as zero.
	logic [15:0] rd_mux;
	always_comb begin
		rd_mux = 16'h0000;
		if (req.addr == `FIRST_DEBUG_CONTROL_OFS)
			rd_mux = {8'h00, first_debug_control_reg};
		else if (req.addr == `TRACE_CONTROL_REGISTER_OFS)
			rd_mux = {8'h00, trace_control_register_reg};
		else if (req.addr == `DEBUG_STATUS_REGISTER_OFS)
			rd_mux = {8'h00, buffer_full_flag_reg, 5'h00, session_reg};
		else if (req.addr == `TRACE_LINE_COUNT_OFS)
			rd_mux = {9'h000, line_count_reg};
		else if (win_rd)
			rd_mux = armed ? `INVALID_WORD : win_word;
	end

	// Power-on-only state: counter, full flag. System reset spares them.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			line_count_reg <= `COUNT_RESET;
			buffer_full_flag_reg <= 1'b0;
		end else begin
			line_count_reg <= line_count_next;
			buffer_full_flag_reg <= buffer_full_flag_next;
		end
	end

	// Control registers and session; system reset clears these.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			first_debug_control_reg <= `CTRL_RESET;
			trace_control_register_reg <= `CTRL_RESET;
			session_reg <= SES_IDLE;
		end else begin
			session_reg <= session_next;
			if (sys_reset) begin
				first_debug_control_reg <= `CTRL_RESET;
				trace_control_register_reg <= `CTRL_RESET;
			end else begin
				if (wr_ctrl1)
					first_debug_control_reg <= req.wdata[7:0];
				else if (finish)
					first_debug_control_reg[`SESSION_ENABLE_BIT] <= 1'b0;
				if (wr_tcr)
					trace_control_register_reg <= req.wdata[7:0];
			end
		end
	end

	// Pointers, mid-trace countdown and the registered outputs.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wptr_reg <= 6'h00;
			rptr_reg <= 6'h00;
			word_idx_reg <= 2'h0;
			mid_left_reg <= 6'h00;
			rdata_reg <= 16'h0000;
			trigger_reg <= 1'b0;
			breakpoint_reg <= 1'b0;
		end else begin
			rdata_reg <= req.rd ? rd_mux : 16'h0000;
			trigger_reg <= final_hit && trace_src;
			breakpoint_reg <= finish && bkpt_en;
			rptr_reg <= rptr_next;
			if (arm_write)
				wptr_reg <= 6'h00;
			else if (line_done)
				wptr_reg <= wptr_inc;
			if (arm_write || sys_reset)
				word_idx_reg <= 2'h0;
			else if (win_rd && !armed)
				word_idx_reg <= word_idx_reg + 2'h1;
			if (final_hit && is_mid)
				mid_left_reg <= `MID_TRACE_LINES;
			else if (line_done && session_reg == SES_POST)
				mid_left_reg <= mid_left_reg - 6'h01;
		end
	end

	// Trace RAM: a half store goes to the upper word first.
	always_ff @(posedge ref_clk) begin
		if (store) begin
			if (!trace_in.half) begin
				mem_hi[wptr_reg] <= trace_in.data[63:32];
				mem_lo[wptr_reg] <= trace_in.data[31:0];
			end else if (!line_count_reg[0])
				mem_hi[wptr_reg] <= trace_in.data[31:0];
			else
				mem_lo[wptr_reg] <= trace_in.data[31:0];
		end
	end

	assign rdata = rdata_reg;
	assign trigger_out = trigger_reg;
	assign breakpoint_req = breakpoint_reg;
	assign session = session_reg;

	// Checks beside the logic they guard.
	count_clear_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		arm_write |=> line_count_reg == 7'h00 && !buffer_full_flag_reg)
		else $error("Counter not cleared by arming write.");

	read_no_dec_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		win_rd && !store && !arm_write |=>
		line_count_reg == $past(line_count_reg))
		else $error("Window read changed the counter.");

	store_count_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		store && !trace_in.half && !arm_write |=>
		line_count_reg == 7'($past(line_count_reg) + 7'h02))
		else $error("Full line store did not add two.");

	full_on_wrap_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		wrap && !arm_write |=> buffer_full_flag_reg
		##1 (buffer_full_flag_reg || $past(arm_write)))
		else $error("Counter wrap did not set full flag.");

	armed_read_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		win_rd && armed && session_next != SES_IDLE |=>
		rdata == `INVALID_WORD && $stable(rptr_reg))
		else $error("Armed window read leaked data or moved pointer.");

	ptr_advance_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		win_rd && !armed && word_idx_reg == 2'h3 && session_next == SES_IDLE
		|=> rptr_reg == 6'($past(rptr_reg) + 6'h01) && word_idx_reg == 2'h0)
		else $error("Read pointer did not advance after fourth word.");

	debug_mode_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		background_debug_mode && !arm_write |=> $stable(line_count_reg))
		else $error("Stored trace while in debug mode.");

	no_source_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		final_hit && !trace_src |=> session_reg == SES_IDLE && !trigger_out
		&& breakpoint_req == $past(bkpt_en))
		else $error("Final state without trace source misbehaved.");

	begin_end_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		begin_done && !sys_reset && !arm_write |=> session_reg == SES_IDLE
		&& line_count_reg == 7'h00 && buffer_full_flag_reg)
		else $error("Begin alignment did not end at 64 lines.");

	trig_pulse_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		final_hit && trace_src |=> trigger_out ##1 !trigger_out)
		else $error("Trigger was not a single pulse after final entry.");

	bkpt_late_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		trigger_out && session_reg == SES_POST |-> !breakpoint_req)
		else $error("Breakpoint raised at trigger instead of session end.");

	bkpt_end_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		finish && bkpt_en |=> breakpoint_req)
		else $error("Finished session raised no breakpoint.");

	begin_hold_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		session_reg == SES_RUN && is_begin && !arm_write
		|=> $stable(line_count_reg))
		else $error("Begin alignment stored before the final state.");

	idle_hold_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		session_reg == SES_IDLE && !arm_write |=> $stable(line_count_reg))
		else $error("Disarmed unit went on storing.");

	end_disarm_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		finish && !wr_ctrl1 |=> session_reg == SES_IDLE
		&& !first_debug_control_reg[`SESSION_ENABLE_BIT])
		else $error("Finished session left the unit armed.");

	oldest_first_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		armed && session_next == SES_IDLE && buffer_full_flag_reg
		&& !arm_write |=> rptr_reg == $past(wptr_reg))
		else $error("Full buffer not read from the oldest line.");

	half_step_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		store && trace_in.half && !arm_write |=>
		line_count_reg == 7'($past(line_count_reg) + 7'h01))
		else $error("Half line store did not add one.");
endmodule : debug_trace_buffer_counter
`default_nettype wire

// file: verification/trace_host_model.sv
// Host model: debug software reaching the trace unit over its register port.
// Assumes one ref_clk domain and a slave that never makes the host wait.
`include "trace_buffer_consts.svh"
`default_nettype none
module trace_host_model (
	input  wire logic                       ref_clk,
	input  wire logic [15:0]                rdata,
	output var  trace_buffer_pkg::reg_req_t req
);
	timeunit 1ns;
	timeprecision 1ps;
	import trace_buffer_pkg::*;

	// The host is idle from time zero so no strobe leaks into reset.
	initial begin
		req = '0;
	end

	// A write is a single strobe cycle; the next access may follow.
	task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		req <= '0;
	endtask : reg_write

	// Read data stand only in the cycle after the strobe, so take them there.
	task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		req <= '0;
		#1 d = rdata;
	endtask : reg_read

	// A line is four word reads through the window, upper word first.
	task automatic read_line(output logic [63:0] ln);
		logic [15:0] w;
		for (int k = 0; k < 4; k++) begin
			reg_read(k[0] ? `TRACE_WINDOW_LOW_OFS
				: `TRACE_WINDOW_HIGH_OFS, w);
			ln = {ln[47:0], w};
		end
	endtask : read_line
endmodule : trace_host_model
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the trace store, counter and session control.
// Assumes the host model drives every register access.
`include "trace_buffer_consts.svh"
`default_nettype none
`define CHK(got, exp, msg) begin \
	samples_checked++; \
	if ((got) !== (exp)) begin \
		fail_count++; \
		$display("MISMATCH t=%0t %s", $time, msg); \
	end \
end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import trace_buffer_pkg::*;
	logic        ref_clk, rst, sys_reset, trigger_out, breakpoint_req;
	logic        enter_first_state, enter_final_state, background_debug_mode;
	logic [15:0] rdata, v;
	logic [63:0] ln, lines [0:3];
	logic [31:0] h1;
	reg_req_t    req;
	trace_in_t   trace_in;
	session_t    session;
	int          fail_count, samples_checked, seed;

	debug_trace_buffer_counter i_debug_trace_buffer_counter (.ref_clk, .rst,
		.sys_reset, .req, .rdata, .trace_in, .enter_first_state,
		.enter_final_state, .background_debug_mode, .trigger_out,
		.breakpoint_req, .session);
	trace_host_model i_trace_host_model (.ref_clk, .rdata, .req);

	// Free-running 250 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Count field as software sees it, in half lines.
	function automatic logic [15:0] cnt_of(input int halves);
		return {9'h000, halves[6:0]};
	endfunction : cnt_of

	task automatic chk_reg(input logic [7:0] a, input logic [15:0] e);
		i_trace_host_model.reg_read(a, v);
		`CHK(v, e, "register value")
	endtask : chk_reg

	task automatic arm(input logic [15:0] tcr, input logic [15:0] c1);
		i_trace_host_model.reg_write(`TRACE_CONTROL_REGISTER_OFS, tcr);
		i_trace_host_model.reg_write(`FIRST_DEBUG_CONTROL_OFS, c1);
	endtask : arm

	// Stores end one step past the taking edge so its updates have landed.
	task automatic store(input logic h, input logic [63:0] d);
		@(posedge ref_clk);
		trace_in <= '{valid: 1'b1, half: h, data: d};
		@(posedge ref_clk);
		trace_in <= '{valid: 1'b0, half: 1'b0, data: ~d};
		#1;
	endtask : store

	task automatic rnd_store();
		store(1'b0, {$random(seed), $random(seed)});
	endtask : rnd_store

	task automatic pulse_first();
		@(posedge ref_clk);
		enter_first_state <= 1'b1;
		@(posedge ref_clk);
		enter_first_state <= 1'b0;
	endtask : pulse_first

	// Trigger and breakpoint are one-cycle pulses seen right after the edge.
	task automatic final_entry(input logic t, input logic b, input session_t s);
		@(posedge ref_clk);
		enter_final_state <= 1'b1;
		@(posedge ref_clk);
		enter_final_state <= 1'b0;
		#1;
		`CHK(trigger_out, t, "trigger pulse")
		`CHK(breakpoint_req, b, "breakpoint pulse")
		`CHK(session, s, "session after final")
	endtask : final_entry

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	// A hang is cut short long after the tests should have ended.
	initial begin
		#100000;
		fail_count++;
		print_verdict();
	end

	// Main sequence.
	initial begin
		seed = 28425;
		rst = 1'b1;
		sys_reset = 1'b0;
		enter_first_state = 1'b0;
		enter_final_state = 1'b0;
		background_debug_mode = 1'b0;
		trace_in = '0;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		chk_reg(`TRACE_LINE_COUNT_OFS, 16'h0000);
		chk_reg(8'h3C, 16'h0000);
		$display("end of test reset");
		// End alignment: nothing stored before the first state is entered.
		arm(16'h0001, 16'h0081);
		#1 `CHK(session, SES_ARMED, "armed")
		rnd_store();
		chk_reg(`TRACE_LINE_COUNT_OFS, 16'h0000);
		chk_reg(`TRACE_WINDOW_HIGH_OFS, `INVALID_WORD);
		pulse_first();
		for (int i = 0; i < 3; i++) begin
			lines[i] = {$random(seed), $random(seed)};
			store(1'b0, lines[i]);
		end
		chk_reg(`TRACE_LINE_COUNT_OFS, cnt_of(6));
		background_debug_mode <= 1'b1;
		rnd_store();
		background_debug_mode <= 1'b0;
		chk_reg(`TRACE_LINE_COUNT_OFS, cnt_of(6));
		h1 = $random(seed);
		store(1'b1, {32'h0, h1});
		chk_reg(`TRACE_LINE_COUNT_OFS, cnt_of(7));
		lines[3] = {h1, $random(seed)};
		store(1'b1, {32'h0, lines[3][31:0]});
		final_entry(1'b1, 1'b1, SES_IDLE);
		chk_reg(`FIRST_DEBUG_CONTROL_OFS, 16'h0001);
		for (int i = 0; i < 4; i++) begin
			i_trace_host_model.read_line(ln);
			`CHK(ln, lines[i], "line read back")
		end
		chk_reg(`TRACE_LINE_COUNT_OFS, cnt_of(8));
		sys_reset <= 1'b1;
		@(posedge ref_clk);
		sys_reset <= 1'b0;
		chk_reg(`TRACE_LINE_COUNT_OFS, cnt_of(8));
		$display("end of test end alignment");
		// Trace source off: breakpoint only; then neither enabled.
		arm(16'h0000, 16'h0081);
		chk_reg(`TRACE_LINE_COUNT_OFS, 16'h0000);
		pulse_first();
		rnd_store();
		chk_reg(`TRACE_LINE_COUNT_OFS, 16'h0000);
		final_entry(1'b0, 1'b1, SES_IDLE);
		arm(16'h0000, 16'h0080);
		final_entry(1'b0, 1'b0, SES_IDLE);
		$display("end of test trace off");
		// Wrap keeps counting with the full flag set; the reserved
		// alignment code must behave as end alignment.
		arm(16'h0007, 16'h0080);
		pulse_first();
		rnd_store();
		lines[0] = {$random(seed), $random(seed)};
		store(1'b0, lines[0]);
		repeat (62) rnd_store();
		chk_reg(`TRACE_LINE_COUNT_OFS, 16'h0000);
		chk_reg(`DEBUG_STATUS_REGISTER_OFS, 16'h0082);
		rnd_store();
		chk_reg(`TRACE_LINE_COUNT_OFS, cnt_of(2));
		final_entry(1'b1, 1'b0, SES_IDLE);
		i_trace_host_model.read_line(ln);
		`CHK(ln, lines[0], "oldest line first after wrap")
		$display("end of test wrap");
		// Mid alignment: exactly 32 lines after the trigger.
		arm(16'h0003, 16'h0080);
		pulse_first();
		repeat (5) rnd_store();
		final_entry(1'b1, 1'b0, SES_POST);
		repeat (31) rnd_store();
		`CHK(session, SES_POST, "mid still tracing")
		rnd_store();
		`CHK(session, SES_IDLE, "mid done")
		rnd_store();
		chk_reg(`TRACE_LINE_COUNT_OFS, cnt_of(74));
		$display("end of test mid alignment");
		// Begin alignment: nothing before final, then 64 lines and disarm.
		arm(16'h0005, 16'h0081);
		pulse_first();
		rnd_store();
		chk_reg(`TRACE_LINE_COUNT_OFS, 16'h0000);
		final_entry(1'b1, 1'b0, SES_POST);
		repeat (63) rnd_store();
		`CHK(session, SES_POST, "begin still armed")
		rnd_store();
		`CHK(session, SES_IDLE, "begin done")
		`CHK(breakpoint_req, 1'b1, "breakpoint at session end")
		chk_reg(`FIRST_DEBUG_CONTROL_OFS, 16'h0001);
		chk_reg(`DEBUG_STATUS_REGISTER_OFS, 16'h0080);
		$display("end of test begin alignment");
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
